// ### logic/sdt_pkg.sv
// Constants shared by the standard down timer and its prescaler.
// Assumes one 200 MHz clock domain with a synchronous active-low reset.
package sdt_pkg;

    // ----------------------------------------------------------------
    // Control byte field positions
    // ----------------------------------------------------------------
    localparam int CTRL_RUN     = 7;  // Run control bit
    localparam int CTRL_SINGLE  = 6;  // 1 single, 0 continuous
    localparam int CTRL_INMD_A  = 5;  // Input mode bit a
    localparam int CTRL_INMD_B  = 4;  // Input mode bit b
    localparam int CTRL_IN_EN   = 3;  // Input section enable
    localparam int CTRL_INTS    = 2;  // 1 routes the external pin instead
    localparam int CTRL_OUTMD_A = 1;  // Output mode bit a
    localparam int CTRL_OUTMD_B = 0;  // Output mode bit b

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] HIGH_RESET  = 8'hFF;
    localparam logic [7:0] LOW_RESET   = 8'hFF;
    localparam logic [7:0] PRESC_RESET = 8'hFF;
    localparam logic [7:0] CTRL_RESET  = 8'h14;

    // ----------------------------------------------------------------
    // Input mode codes {input_mode_bit_a, input_mode_bit_b}
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_EVENT   = 2'h0;
    localparam logic [1:0] MODE_GATED   = 2'h1;
    localparam logic [1:0] MODE_TRIGGER = 2'h2;
    localparam logic [1:0] MODE_RETRIG  = 2'h3;

    // ----------------------------------------------------------------
    // Timing: internal clock divided by four feeds the prescaler
    // ----------------------------------------------------------------
    localparam int         CLK_DIV  = 4;
    localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);

endpackage

// ### logic/sdt_prescaler.sv
// Programmable 8-bit prescaler: one output tick per (ratio + 1) input ticks.
// Assumes input ticks are one-cycle pulses on clk_i.
module sdt_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       src_tick_i,
    input  wire logic       restart_i,
    input  wire logic [7:0] ratio_i,
    output logic            tick_o
);

    typedef struct packed {
        logic [7:0] cnt;
    } sdt_presc_state_type;

    sdt_presc_state_type st;
    sdt_presc_state_type next_st;

    // Compare with >= so a smaller ratio written on the fly applies at once
    assign tick_o = src_tick_i && (st.cnt >= ratio_i);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (restart_i) begin
            next_st.cnt = 8'h00;
        end else if (src_tick_i) begin
            next_st.cnt = tick_o ? 8'h00 : st.cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_presc_bypass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ratio_i == 8'h00 && src_tick_i) |-> tick_o)
        else $error("prescaler ratio zero did not pass tick");

endmodule

// ### logic/sdt_timer.sv
// Standard 16-bit down timer with 8-bit prescaler, input and output modes.
// Assumes software writes arrive as one-cycle strobes on clk_i; pins are async.
//
// Operation
// - 16-bit down counter behind 8-bit prescaler; constant held as high and low bytes.
// - Prescaler fed by internal clock over four, oscillator clock, or input pin.
// - Counter underflow at zero is end of count and may request interrupt.
// - End-of-count request is placed on an external interrupt channel.
// - Setting run bit starts counting next cycle; clearing it stops counting.
// - Restart resumes held count, or loads constant written while stopped.
// - Constant written while running loads at end of count; prescaler at once.
// - Counter bytes and prescaler reset to all ones.
// - Single mode: at end of count reload constant and clear run bit.
// - Continuous mode: at end of count reload and keep counting.
// - Single/continuous bit writable anytime, together with run bit.
// - Input section disabled: internal clock over four, pin ignored.
// - Event mode: each falling input edge, or each rising oscillator edge when selected, is a counting clock.
// - Gated mode: count at internal clock over four while pin high.
// - Triggerable mode: count after run set and a falling edge.
// - Retriggerable: falling edge while running reloads constants; ignored when stopped.
// - Prescaler ratio is value plus one.
// - Output mode zero holds output pin high.
// - Square wave mode toggles output pin at every end of count.
// - PWM mode copies output mode bit b to pin at end of count.
module sdt_timer (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  write_data_i,
    input  wire logic        write_high_i,
    input  wire logic        write_low_i,
    input  wire logic        write_presc_i,
    input  wire logic        write_ctrl_i,
    input  wire logic        osc_source_select_i,
    input  wire logic        timer_input_pin_i,
    input  wire logic        oscillator_derived_clock_i,
    input  wire logic        ext_irq_pin_i,
    output logic [15:0]      count_o,
    output logic [7:0]       prescaler_value_o,
    output logic [7:0]       timer_control_o,
    output logic             timer_output_pin_o,
    output logic             irq_channel_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        pin_meta;
        logic        pin_sync;
        logic        pin_prev;
        logic        osc_meta;
        logic        osc_sync;
        logic        osc_prev;
        logic        ext_meta;
        logic        ext_sync;
        logic [1:0]  div;
        logic [7:0]  const_high;
        logic [7:0]  const_low;
        logic [7:0]  presc;
        logic [7:0]  ctrl;
        logic [15:0] count;
        logic        pending;
        logic        armed;
        logic        out_pin;
        logic        irq;
    } sdt_state_type;

    sdt_state_type st;
    sdt_state_type next_st;

    logic        run;
    logic        input_en;
    logic [1:0]  in_mode;
    logic [1:0]  out_mode;
    logic        div_tick;
    logic        pin_fall;
    logic        osc_rise;
    logic        count_en;
    logic        raw_src;
    logic        src_tick;
    logic        count_tick;
    logic        eoc;
    logic        retrig;
    logic        start_load;
    logic        presc_restart;
    logic [15:0] constant;

    // ----------------------------------------------------------------
    // Decode of control byte and pin events
    // ----------------------------------------------------------------
    assign run      = st.ctrl[sdt_pkg::CTRL_RUN];
    assign input_en = st.ctrl[sdt_pkg::CTRL_IN_EN];
    assign in_mode  = {st.ctrl[sdt_pkg::CTRL_INMD_A], st.ctrl[sdt_pkg::CTRL_INMD_B]};
    assign out_mode = {st.ctrl[sdt_pkg::CTRL_OUTMD_A], st.ctrl[sdt_pkg::CTRL_OUTMD_B]};
    assign constant = {st.const_high, st.const_low};
    assign div_tick = (st.div == sdt_pkg::DIV_LAST);
    assign pin_fall = st.pin_prev && !st.pin_sync;
    assign osc_rise = st.osc_sync && !st.osc_prev;

    // Counting allowed: run bit, plus a seen trigger in triggerable mode
    assign count_en = run && !(input_en && in_mode == sdt_pkg::MODE_TRIGGER && !st.armed);

    // Prescaler source selection
    always_comb begin
        if (!input_en) begin
            raw_src = div_tick;
        end else begin
            unique case (in_mode)
                sdt_pkg::MODE_EVENT: raw_src = osc_source_select_i ? osc_rise : pin_fall;
                sdt_pkg::MODE_GATED: raw_src = div_tick && st.pin_sync;
                default:             raw_src = div_tick;
            endcase
        end
    end

    assign src_tick      = raw_src && count_en;
    assign retrig        = input_en && in_mode == sdt_pkg::MODE_RETRIG && run && pin_fall;
    assign start_load    = write_ctrl_i && write_data_i[sdt_pkg::CTRL_RUN] && !run
                           && st.pending;
    assign presc_restart = start_load || retrig;
    assign eoc           = count_tick && (st.count == 16'h0000);

    // Prescaler instance
    sdt_prescaler u_presc (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .src_tick_i (src_tick),
        .restart_i  (presc_restart),
        .ratio_i    (st.presc),
        .tick_o     (count_tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Two-stage synchronisers, third stage for edges
        next_st.pin_meta = timer_input_pin_i;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;
        next_st.osc_meta = oscillator_derived_clock_i;
        next_st.osc_sync = st.osc_meta;
        next_st.osc_prev = st.osc_sync;
        next_st.ext_meta = ext_irq_pin_i;
        next_st.ext_sync = st.ext_meta;

        // Internal clock divider by four
        next_st.div = st.div + 2'h1;

        // Software writes to constants and prescaler
        if (write_high_i) begin
            next_st.const_high = write_data_i;
        end
        if (write_low_i) begin
            next_st.const_low = write_data_i;
        end
        if ((write_high_i || write_low_i) && !run) begin
            next_st.pending = 1'b1;
        end
        if (write_presc_i) begin
            next_st.presc = write_data_i;
        end

        // Control write updates all fields at once
        if (write_ctrl_i) begin
            next_st.ctrl = write_data_i;
        end
        // Single mode clears run; a same-cycle software start wins
        if (eoc && st.ctrl[sdt_pkg::CTRL_SINGLE]
                && !(write_ctrl_i && write_data_i[sdt_pkg::CTRL_RUN])) begin
            next_st.ctrl[sdt_pkg::CTRL_RUN] = 1'b0;
        end

        // Trigger arm for triggerable mode
        if (!run) begin
            next_st.armed = 1'b0;
        end else if (pin_fall) begin
            next_st.armed = 1'b1;
        end

        // Counter
        if (start_load) begin
            next_st.count   = constant;
            next_st.pending = write_high_i || write_low_i; // Same-cycle write wins
        end else if (retrig) begin
            next_st.count = constant;
        end else if (count_tick) begin
            if (eoc) begin
                next_st.count = constant;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end

        // Output pin
        if ({next_st.ctrl[sdt_pkg::CTRL_OUTMD_A], next_st.ctrl[sdt_pkg::CTRL_OUTMD_B]}
                == 2'h0) begin
            next_st.out_pin = 1'b1;
        end else if (eoc) begin
            if (out_mode[1]) begin
                next_st.out_pin = out_mode[0];
            end else begin
                next_st.out_pin = !st.out_pin;
            end
        end

        // Interrupt channel: timer end of count or external pin
        next_st.irq = next_st.ctrl[sdt_pkg::CTRL_INTS] ? st.ext_sync : eoc;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st            <= '0;
            st.const_high <= sdt_pkg::HIGH_RESET;
            st.const_low  <= sdt_pkg::LOW_RESET;
            st.presc      <= sdt_pkg::PRESC_RESET;
            st.ctrl       <= sdt_pkg::CTRL_RESET;
            st.count      <= {sdt_pkg::HIGH_RESET, sdt_pkg::LOW_RESET};
            st.out_pin    <= 1'b1;
            st.pin_meta   <= 1'b1; // Idle pin level, no false edge
            st.pin_sync   <= 1'b1;
            st.pin_prev   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign count_o            = st.count;
    assign prescaler_value_o  = st.presc;
    assign timer_control_o    = st.ctrl;
    assign timer_output_pin_o = st.out_pin;
    assign irq_channel_o      = st.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_eoc_single;
        eoc && st.ctrl[sdt_pkg::CTRL_SINGLE] && !write_ctrl_i;
    endsequence

    sequence s_eoc_cont;
        eoc && !st.ctrl[sdt_pkg::CTRL_SINGLE] && !write_ctrl_i;
    endsequence

    sequence s_start_pending;
        write_ctrl_i && write_data_i[sdt_pkg::CTRL_RUN] && !run && st.pending;
    endsequence

    chk_eoc_reload: assert property (eoc && !retrig |=> st.count == $past(constant))
        else $error("counter not reloaded at end of count");

    chk_single_stop: assert property (s_eoc_single |=> !run)
        else $error("single mode did not clear run");

    chk_cont_keep: assert property (s_eoc_cont |=> run)
        else $error("continuous mode lost run");

    chk_start_load: assert property (s_start_pending |=> st.count == $past(constant)
                                     && st.pending == $past(write_high_i || write_low_i))
        else $error("pending constant not loaded on start");

    chk_stop_hold: assert property (!run && !write_ctrl_i |=> $stable(st.count))
        else $error("count moved while stopped");

    chk_square_toggle: assert property (eoc && out_mode == 2'h1 && !write_ctrl_i
                                        |=> st.out_pin != $past(st.out_pin))
        else $error("square wave did not toggle");

    chk_pwm_copy: assert property (eoc && out_mode[1] && !write_ctrl_i
                                   |=> st.out_pin == $past(out_mode[0]))
        else $error("pwm level not copied");

    chk_idle_high: assert property (out_mode == 2'h0 |-> st.out_pin)
        else $error("output pin not high with output disabled");

    chk_gate_hold: assert property (run && input_en && in_mode == sdt_pkg::MODE_GATED
                                    && !st.pin_sync && !write_ctrl_i
                                    |=> $stable(st.count))
        else $error("gated count moved with gate low");

    chk_trig_wait: assert property (run && input_en && in_mode == sdt_pkg::MODE_TRIGGER
                                    && !st.armed |-> !src_tick)
        else $error("triggerable counted before trigger");

    chk_irq_route: assert property (eoc && !st.ctrl[sdt_pkg::CTRL_INTS] && !write_ctrl_i
                                    |=> irq_channel_o)
        else $error("end of count not placed on channel");

    chk_retrig_load: assert property (retrig |=> st.count == $past(constant))
        else $error("retrigger did not reload constant");

    chk_event_edge: assert property (run && input_en && in_mode == sdt_pkg::MODE_EVENT
                                     && !osc_source_select_i && !pin_fall |-> !src_tick)
        else $error("event counter ticked without falling edge");

    chk_internal_src: assert property (run && !input_en && !div_tick |-> !src_tick)
        else $error("internal source ticked off the divider");

endmodule

// ### tb/sdt_pin_src.sv
// Model of the signal source that drives the timer input pin.
// Assumes the bench calls its tasks; the pin only moves at falling clock edges.
module sdt_pin_src (
    input  wire logic clk_i,
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle level is high
    initial pin_o = 1'b1;

    // Steady level for gated use
    task automatic set_level(input logic lvl);
        @(negedge clk_i);
        pin_o = lvl;
    endtask

    // Falling edges ten clocks apart, above the eight-clock minimum
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            pin_o = 1'b1;
            repeat (5) @(negedge clk_i);
            pin_o = 1'b0;
            repeat (4) @(negedge clk_i);
        end
        @(negedge clk_i);
        pin_o = 1'b1;
    endtask
endmodule

// ### tb/standard_down_timer_tb.sv
// Self-checking bench for the standard down timer.
// Assumes a 200 MHz clock; inputs move at falling edges.
module standard_down_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam int H = 0;
    localparam int L = 1;
    localparam int P = 2;
    localparam int C = 3;
    logic        clk, rstn, wr_h, wr_l, wr_p, wr_c, osc_sel, osc_clk, ext_irq;
    logic        pin, out_pin, irq, lvl;
    logic [7:0]  wdata, presc, ctrl;
    logic [15:0] count, held;
    int          fails = 0;
    int          check_count = 0;
    int          n;

    sdt_pin_src src (.clk_i(clk), .pin_o(pin));

    sdt_timer dut (
        .clk_i(clk), .rstn_i(rstn), .write_data_i(wdata), .write_high_i(wr_h),
        .write_low_i(wr_l), .write_presc_i(wr_p), .write_ctrl_i(wr_c),
        .osc_source_select_i(osc_sel), .timer_input_pin_i(pin),
        .oscillator_derived_clock_i(osc_clk), .ext_irq_pin_i(ext_irq),
        .count_o(count), .prescaler_value_o(presc), .timer_control_o(ctrl),
        .timer_output_pin_o(out_pin), .irq_channel_o(irq)
    );

    // Clocks; oscillator gives one rising edge per 16 cycles
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        osc_clk = 1'b0;
        forever #40 osc_clk = ~osc_clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input int sel, input logic [7:0] d);
        @(negedge clk);
        wdata = d;
        wr_h  = (sel == H);
        wr_l  = (sel == L);
        wr_p  = (sel == P);
        wr_c  = (sel == C);
        @(negedge clk);
        wr_h  = 1'b0;
        wr_l  = 1'b0;
        wr_p  = 1'b0;
        wr_c  = 1'b0;
    endtask
    // Cycles up to the next interrupt pulse, bounded
    task automatic wait_irq(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (irq !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) begin
            fails++;
            final_report();
        end
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        wdata = 8'h00;
        wr_h = 1'b0;
        wr_l = 1'b0;
        wr_p = 1'b0;
        wr_c = 1'b0;
        osc_sel = 1'b0;
        ext_irq = 1'b0;
        idle(2);
        rstn = 1'b1;
        chk_val("count", 16'hFFFF, count);
        chk_val("presc", 16'h00FF, {8'h00, presc});
        chk_val("ctrl", 16'h0014, {8'h00, ctrl});
        chk_flag("out", 1'b1, out_pin);
        chk_flag("irq", 1'b0, irq);
        // Continuous, internal clock, square wave; pin activity ignored
        wr(H, 8'h00);
        wr(L, 8'h02);
        wr(P, 8'h00);
        wr(C, 8'h81);
        wait_irq(n);
        lvl = out_pin;
        fork
            src.pulse(4);
            wait_irq(n);
        join
        chk_val("period", 16'h000C, 16'(n));
        chk_flag("square", ~lvl, out_pin);
        // New constant while running waits for end of count
        wr(L, 8'h05);
        chk_flag("no load", 1'b1, count <= 16'h0002);
        wait_irq(n);
        wait_irq(n);
        chk_val("period", 16'h0018, 16'(n));
        // Prescaler written while running acts at once
        wr(L, 8'h3F);
        wait_irq(n);
        wait_irq(n);
        wr(P, 8'h03);
        chk_val("presc", 16'h0003, {8'h00, presc});
        wait_irq(n);
        chk_flag("presc now", 1'b1, n > 600);
        wait_irq(n);
        chk_val("period", 16'h0400, 16'(n));
        // Stop holds, restart resumes, pending constant loads
        idle(20);
        wr(C, 8'h01);
        held = count;
        idle(40);
        chk_val("stopped", held, count);
        wr(C, 8'h81);
        idle(1);
        chk_flag("resume", 1'b1, count <= held && count + 16'h0002 > held);
        wr(C, 8'h01);
        wr(L, 8'h20);
        wr(C, 8'h81);
        idle(1);
        chk_val("pending", 16'h0020, count);
        // Single mode with PWM output
        wr(P, 8'h00);
        wr(L, 8'h02);
        wr(C, 8'hC3);
        chk_val("ctrl", 16'h00C3, {8'h00, ctrl});
        wait_irq(n);
        chk_flag("run", 1'b0, ctrl[7]);
        chk_flag("pwm", 1'b1, out_pin);
        idle(20);
        chk_val("single", 16'h0002, count);
        wr(C, 8'hC2);
        wait_irq(n);
        chk_flag("pwm", 1'b0, out_pin);
        chk_val("ctrl", 16'h0042, {8'h00, ctrl});
        wr(C, 8'h00);
        chk_flag("no output", 1'b1, out_pin);
        // Interrupt channel handed to the external pin
        wr(C, 8'h04);
        ext_irq = 1'b1;
        idle(4);
        chk_flag("ext irq", 1'b1, irq);
        ext_irq = 1'b0;
        idle(4);
        chk_flag("ext irq", 1'b0, irq);
        // Event counter on pin edges, then on oscillator edges
        wr(H, 8'h01);
        wr(L, 8'h00);
        wr(C, 8'h88);
        idle(2);
        chk_val("event", 16'h0100, count);
        src.pulse(5);
        idle(5);
        chk_val("event", 16'h00FB, count);
        osc_sel = 1'b1;
        idle(160);
        chk_flag("osc", 1'b1, count < 16'h00FB && count > 16'h00EE);
        osc_sel = 1'b0;
        // Gated mode
        wr(C, 8'h00);
        wr(L, 8'h00);
        src.set_level(1'b0);
        wr(C, 8'h98);
        idle(40);
        chk_val("gate low", 16'h0100, count);
        src.set_level(1'b1);
        idle(40);
        chk_flag("gate high", 1'b1, count < 16'h0100 && count > 16'h00F0);
        // Triggerable mode
        wr(C, 8'h00);
        wr(L, 8'h00);
        wr(C, 8'hA8);
        idle(40);
        chk_val("armed", 16'h0100, count);
        src.pulse(1);
        idle(20);
        chk_flag("trig", 1'b1, count < 16'h0100);
        wr(C, 8'h28);
        held = count;
        idle(20);
        chk_val("trig stop", held, count);
        // Retriggerable mode
        wr(C, 8'h00);
        wr(L, 8'h00);
        wr(C, 8'hB8);
        idle(40);
        src.pulse(1);
        chk_flag("retrig", 1'b1, count >= 16'h00FE);
        wr(C, 8'h38);
        held = count;
        src.pulse(1);
        idle(4);
        chk_val("retrig stop", held, count);
        final_report();
    end
endmodule
